// [rtl/spc_counter_regs.svh]
/*
 * Register map, field positions, reset values and counter constants.
 * Assumes inclusion by bare name from the counter and its bench.
 */
`ifndef SPC_COUNTER_REGS_SVH
`define SPC_COUNTER_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SPC_CTRL_OFS 8'h00
`define SPC_STATUS_OFS 8'h04
`define SPC_WRAPS_OFS 8'h08
`define SPC_FLAGS_OFS 8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPC_CTRL_WRAPEN_BIT 0
`define SPC_STATUS_CARRY_BIT 4
`define SPC_STATUS_MODE_LSB 5
`define SPC_FLAG_WRAP_BIT 0
`define SPC_FLAG_LOAD_BIT 1
`define SPC_FLAG_ZERO_BIT 2

// ----------------------------------------
// Reset values and counter constants
// ----------------------------------------
`define SPC_CTRL_RST 1'h0
`define SPC_FLAGS_RST 3'h0
`define SPC_WRAPS_RST 16'h0000
`define SPC_COUNT_RST 4'h0
`define SPC_TERMINAL_COUNT 4'hF
`define SPC_COUNT_STEP 4'h1

`endif

// [rtl/spc_pkg.sv]
/*
 * Types shared by the presettable counter and its bench.
 * Assumes nothing of its surroundings.
 */
package spc_pkg;

	// Operating mode taken at the last clock edge; clear is forced without an edge
	typedef enum logic [1:0] {
		MODE_CLEAR,
		MODE_LOAD,
		MODE_COUNT,
		MODE_HOLD
	} spc_mode_t;

endpackage

// [rtl/spc_counter.sv]
/*
 * Synchronous presettable 4-bit binary up-counter with terminal carry,
 * plus an APB slave that shows its state and counts its wraps.
 * Assumes pin inputs synchronous to core_clk and an APB master on core_clk.
 */
// Contract
// - Count up when both gates and preset high
// - Low preset loads data regardless of gates
// - Low clear zeroes count and carry immediately
// - Either gate low holds the count
// - Carry high at count 15 with gate two
// - Only gate two gates the carry
// - Load, count or hold decided only at clock edge
// - Count wraps from 15 to 0
`timescale 1ns/1ps
`include "spc_counter_regs.svh"

module spc_counter (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic asyncZeroN,
	input wire logic presetN,
	input wire logic [3:0] presetData,
	input wire logic countGateFirst,
	input wire logic countGateSecond,
	output logic [3:0] countBits,
	output logic terminalCarryOut,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ----------------------------------------
	// Counter core
	// ----------------------------------------
	logic clrAll;
	logic countEn;
	logic [3:0] count_r;
	logic [3:0] count_nxt;
	spc_pkg::spc_mode_t mode_r;
	spc_pkg::spc_mode_t mode_nxt;

	// Clear pin and system reset both act without the clock
	assign clrAll = rst | ~asyncZeroN;
	assign countEn = countGateFirst & countGateSecond;

	// Next count: load beats count, count beats hold
	always_comb begin
		count_nxt = count_r;
		mode_nxt = spc_pkg::MODE_HOLD;
		if (!presetN) begin
			count_nxt = presetData;
			mode_nxt = spc_pkg::MODE_LOAD;
		end else if (countEn) begin
			count_nxt = count_r + `SPC_COUNT_STEP;
			mode_nxt = spc_pkg::MODE_COUNT;
		end
	end

	// Preset, data and gates act only through the sampled next value
	always_ff @(posedge core_clk or posedge clrAll) begin
		if (clrAll) begin
			count_r <= `SPC_COUNT_RST;
			mode_r <= spc_pkg::MODE_CLEAR;
		end else begin
			count_r <= count_nxt;
			mode_r <= mode_nxt;
		end
	end

	assign countBits = count_r;

	// Carry follows gate two without a clock; clear forces count 0
	assign terminalCarryOut = countGateSecond &
		(count_r == `SPC_TERMINAL_COUNT);

	// ----------------------------------------
	// APB slave and bookkeeping registers
	// ----------------------------------------
	logic setupPh;
	logic wrAcc;
	logic mapped;
	logic wrapEvt;
	logic [2:0] flagSet;
	logic [2:0] flagClr;
	logic [31:0] rdMux;
	logic ctrl_r;
	logic ctrl_nxt;
	logic [2:0] flags_r;
	logic [2:0] flags_nxt;
	logic [15:0] wraps_r;
	logic [15:0] wraps_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pready_r;
	logic pready_nxt;
	logic pslverr_r;
	logic pslverr_nxt;

	assign setupPh = psel & ~penable;
	assign wrAcc = psel & penable & pready_r & pwrite;

	// Events seen by the bookkeeping logic at this edge
	assign wrapEvt = asyncZeroN & presetN & countEn &
		(count_r == `SPC_TERMINAL_COUNT);
	assign flagSet[`SPC_FLAG_WRAP_BIT] = wrapEvt;
	assign flagSet[`SPC_FLAG_LOAD_BIT] = asyncZeroN & ~presetN;
	assign flagSet[`SPC_FLAG_ZERO_BIT] = ~asyncZeroN;

	// Read decode; unmapped offsets answer with an error
	always_comb begin
		mapped = 1'b1;
		rdMux = 32'h0000_0000;
		case (paddr)
			`SPC_CTRL_OFS: begin
				rdMux[`SPC_CTRL_WRAPEN_BIT] = ctrl_r;
			end
			`SPC_STATUS_OFS: begin
				rdMux[3:0] = count_r;
				rdMux[`SPC_STATUS_CARRY_BIT] = terminalCarryOut;
				rdMux[`SPC_STATUS_MODE_LSB +: 2] = mode_r;
			end
			`SPC_WRAPS_OFS: begin
				rdMux[15:0] = wraps_r;
			end
			`SPC_FLAGS_OFS: begin
				rdMux[2:0] = flags_r;
			end
			default: begin
				mapped = 1'b0;
			end
		endcase
	end

	// Next register values; a set in the clear cycle wins
	always_comb begin
		ctrl_nxt = ctrl_r;
		flagClr = 3'h0;
		wraps_nxt = wraps_r;
		if (wrAcc && paddr == `SPC_CTRL_OFS) begin
			ctrl_nxt = pwdata[`SPC_CTRL_WRAPEN_BIT];
		end
		if (wrAcc && paddr == `SPC_FLAGS_OFS) begin
			flagClr = pwdata[2:0];
		end
		if (wrAcc && paddr == `SPC_WRAPS_OFS) begin
			wraps_nxt = `SPC_WRAPS_RST;
		end
		if (wrapEvt && ctrl_r) begin
			wraps_nxt = wraps_nxt + 16'h0001;
		end
		flags_nxt = (flags_r & ~flagClr) | flagSet;
		pready_nxt = setupPh;
		pslverr_nxt = setupPh & ~mapped;
		prdata_nxt = (setupPh && !pwrite) ? rdMux : 32'h0000_0000;
	end

	// Register the bus side
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= `SPC_CTRL_RST;
			flags_r <= `SPC_FLAGS_RST;
			wraps_r <= `SPC_WRAPS_RST;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			flags_r <= flags_nxt;
			wraps_r <= wraps_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------

	// Edge conditions for count, load and hold, clear released over the cycle
	sequence sCountCond;
		asyncZeroN && presetN && countGateFirst && countGateSecond ##1 asyncZeroN;
	endsequence

	sequence sLoadCond;
		asyncZeroN && !presetN ##1 asyncZeroN;
	endsequence

	sequence sHoldCond;
		asyncZeroN && presetN && !(countGateFirst && countGateSecond) ##1 asyncZeroN;
	endsequence

	a_count_step: assert property (@(posedge core_clk) disable iff (rst)
		sCountCond |-> countBits == 4'($past(countBits) + 4'h1))
		else $error("count did not step by one");

	a_load_data: assert property (@(posedge core_clk) disable iff (rst)
		sLoadCond |-> countBits == $past(presetData) && mode_r == spc_pkg::MODE_LOAD)
		else $error("preset data not loaded");

	a_clear_zero: assert property (@(posedge core_clk) disable iff (rst)
		!asyncZeroN |-> countBits == 4'h0 && !terminalCarryOut)
		else $error("clear did not zero count and carry");

	a_hold_gate: assert property (@(posedge core_clk) disable iff (rst)
		sHoldCond |-> $stable(countBits))
		else $error("count moved while a gate was low");

	a_carry_term: assert property (@(posedge core_clk) disable iff (rst)
		terminalCarryOut == (countGateSecond && countBits == 4'hF))
		else $error("carry does not match terminal count");

	a_carry_first: assert property (@(posedge core_clk) disable iff (rst)
		countBits == 4'hF && countGateSecond && !countGateFirst |-> terminalCarryOut)
		else $error("gate one affected the carry");

	// Two edges with clear released: the count seen at the second is the one the first edge set
	sequence sEdgeKept;
		asyncZeroN ##1 asyncZeroN;
	endsequence

	a_mode_edge: assert property (@(posedge core_clk) disable iff (rst)
		sEdgeKept |-> countBits == (!$past(presetN) ? $past(presetData) :
			($past(countGateFirst) && $past(countGateSecond)) ?
			4'($past(countBits) + 4'h1) : $past(countBits)))
		else $error("count not set by the inputs sampled at the edge");

	a_wrap_zero: assert property (@(posedge core_clk) disable iff (rst)
		countBits == 4'hF ##0 sCountCond |-> countBits == 4'h0 ##1 flags_r[0])
		else $error("count did not wrap to zero");

	a_carry_comb: assert property (@(posedge core_clk) disable iff (rst)
		countBits == 4'hF && $rose(countGateSecond) |-> terminalCarryOut)
		else $error("carry waited for a clock edge");

	// Mode shown on the status port after counting and holding edges
	a_mode_count: assert property (@(posedge core_clk) disable iff (rst)
		sCountCond |-> mode_r == spc_pkg::MODE_COUNT)
		else $error("mode not shown as counting");

	a_mode_hold: assert property (@(posedge core_clk) disable iff (rst)
		!rst ##0 sHoldCond |-> mode_r == spc_pkg::MODE_HOLD)
		else $error("mode not shown as holding");

	// ----------------------------------------
	// Bus and bookkeeping assertions
	// ----------------------------------------

	// Bus handshake: a setup edge opens one access cycle with ready high
	sequence sBusSetup;
		psel && !penable;
	endsequence

	sequence sBusAccess;
		psel && penable && pready;
	endsequence

	a_ready_setup: assert property (@(posedge core_clk) disable iff (rst)
		sBusSetup |=> pready)
		else $error("ready missing in the access cycle");

	a_ready_pulse: assert property (@(posedge core_clk) disable iff (rst)
		sBusAccess |=> !pready)
		else $error("ready stood longer than one cycle");

	a_err_unmapped: assert property (@(posedge core_clk) disable iff (rst)
		sBusSetup ##0 !(paddr inside {`SPC_CTRL_OFS, `SPC_STATUS_OFS, `SPC_WRAPS_OFS,
			`SPC_FLAGS_OFS}) |=> pready && pslverr)
		else $error("unmapped offset answered without error");

	a_err_mapped: assert property (@(posedge core_clk) disable iff (rst)
		sBusSetup ##0 (paddr inside {`SPC_CTRL_OFS, `SPC_STATUS_OFS, `SPC_WRAPS_OFS,
			`SPC_FLAGS_OFS}) |=> pready && !pslverr)
		else $error("mapped offset answered with error");

	a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data shown outside the access cycle");

	a_ctrl_write: assert property (@(posedge core_clk) disable iff (rst)
		sBusAccess ##0 (pwrite && paddr == `SPC_CTRL_OFS) |=>
			ctrl_r == $past(pwdata[`SPC_CTRL_WRAPEN_BIT]))
		else $error("control write did not land");

	// Sticky flags, clear mode and the wrap counter; an event beats a clear
	a_flag_load: assert property (@(posedge core_clk) disable iff (rst)
		asyncZeroN && !presetN |=> flags_r[`SPC_FLAG_LOAD_BIT])
		else $error("load flag not set");

	a_flag_clear: assert property (@(posedge core_clk) disable iff (rst)
		!asyncZeroN |=> flags_r[`SPC_FLAG_ZERO_BIT])
		else $error("clear flag not set");

	a_clear_mode: assert property (@(posedge core_clk) disable iff (rst)
		!asyncZeroN |-> mode_r == spc_pkg::MODE_CLEAR)
		else $error("mode not shown as cleared");

	a_wrap_count: assert property (@(posedge core_clk) disable iff (rst)
		ctrl_r && asyncZeroN && presetN && countGateFirst && countGateSecond &&
			countBits == 4'hF && !(psel && penable && pready && pwrite &&
			paddr == `SPC_WRAPS_OFS) |=> wraps_r == 16'($past(wraps_r) + 16'h0001))
		else $error("wrap not counted");

	a_wrap_clear: assert property (@(posedge core_clk) disable iff (rst)
		sBusAccess ##0 (pwrite && paddr == `SPC_WRAPS_OFS && countBits != 4'hF) |=>
			wraps_r == 16'h0000)
		else $error("wrap counter not cleared by a write");

endmodule

// [testbench/spc_next_stage.sv]
/*
 * Model of a more significant cascaded counter stage.
 * Assumes the lower stage carry and the shared core clock.
 */
`timescale 1ns/1ps
module spc_next_stage (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic carryIn,
	output logic [3:0] upperCount
);
	// -----------------
	// Cascade stage
	// -----------------
	// Steps only on edges where the lower carry enables it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			upperCount <= 4'h0;
		end else if (carryIn) begin
			upperCount <= upperCount + 4'h1;
		end
	end
endmodule

// [testbench/spc_counter_test.sv]
/*
 * Self-checking bench for the presettable counter and its APB slave.
 * Assumes the counter, its register header and the cascade stage model.
 */
`timescale 1ns/1ps
`include "spc_counter_regs.svh"
module spc_counter_test;
	logic core_clk = 0, rst = 1, asyncZeroN = 1, presetN = 1;
	logic countGateFirst = 0, countGateSecond = 0, psel = 0, penable = 0, pwrite = 0;
	logic [3:0] presetData = 4'h0, countBits, upperCount;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic terminalCarryOut, pready, pslverr, err;
	int miscompares = 0, tests_run = 0;
	spc_counter DUT (.core_clk(core_clk), .rst(rst), .asyncZeroN(asyncZeroN),
		.presetN(presetN), .presetData(presetData), .countGateFirst(countGateFirst),
		.countGateSecond(countGateSecond), .countBits(countBits),
		.terminalCarryOut(terminalCarryOut), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	spc_next_stage upper (.core_clk(core_clk), .rst(rst), .carryIn(terminalCarryOut),
		.upperCount(upperCount));
	// -----------------
	// Helpers
	// -----------------
	// Clock of 20 ns
	initial begin
		forever #10 core_clk = ~core_clk;
	end
	// Compare and report
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask
	// Drive pins just after an edge, then let outputs settle
	task automatic pins(input logic z, p, g1, g2, input logic [3:0] d);
		@(posedge core_clk);
		asyncZeroN <= z;
		presetN <= p;
		countGateFirst <= g1;
		countGateSecond <= g2;
		presetData <= d;
		#1;
	endtask
	// One APB transfer, waiting for pready under a bound
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		@(posedge core_clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge core_clk);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		if (n == 20) begin
			miscompares++;
			close_out();
		end
	endtask
	// -----------------
	// Scenarios
	// -----------------
	// Load 12, count through the wrap and into the next stage
	task automatic t_count;
		logic [3:0] up0;
		int i;
		up0 = upperCount;
		pins(1, 0, 0, 0, 4'hC);
		chk("count before edge", 32'h0, countBits);
		pins(1, 1, 1, 1, 4'h0);
		chk("loaded", 32'hC, countBits);
		for (i = 13; i < 19; i++) begin
			pins(1, 1, 1, 1, 4'h0);
			chk("counted", i % 16, countBits);
			chk("carry", i == 15, terminalCarryOut);
		end
		chk("next stage", up0 + 4'h1, upperCount);
	endtask
	// Gate one holds but leaves carry; gate two holds and kills carry
	task automatic t_gates;
		pins(1, 0, 0, 0, 4'hF);
		pins(1, 1, 0, 1, 4'h0);
		pins(1, 1, 0, 1, 4'h0);
		chk("hold gate one", 32'hF, countBits);
		chk("carry gate one low", 32'h1, terminalCarryOut);
		pins(1, 1, 1, 0, 4'h0);
		chk("carry gate two low", 32'h0, terminalCarryOut);
		pins(1, 1, 1, 0, 4'h0);
		chk("hold gate two", 32'hF, countBits);
	endtask
	// Clear drops count and carry before any edge
	task automatic t_clear;
		pins(1, 1, 1, 1, 4'h0);
		pins(1, 0, 1, 1, 4'hF);
		pins(0, 0, 1, 1, 4'h7);
		chk("cleared count", 32'h0, countBits);
		chk("cleared carry", 32'h0, terminalCarryOut);
		pins(1, 1, 0, 0, 4'h0);
	endtask
	// Status, control and an unmapped place over the bus
	task automatic t_bus;
		apb(0, `SPC_STATUS_OFS, 32'h0);
		chk("status count", 32'h0, rd & 32'hF);
		chk("status hold", 32'(spc_pkg::MODE_HOLD) << `SPC_STATUS_MODE_LSB, rd);
		chk("status error", 32'h0, err);
		apb(0, `SPC_WRAPS_OFS, 32'h0);
		chk("wraps while off", 32'h0, rd);
		apb(1, `SPC_CTRL_OFS, 32'h1);
		apb(0, `SPC_CTRL_OFS, 32'h0);
		chk("ctrl", 32'h1, rd);
		apb(0, 8'h10, 32'h0);
		chk("unmapped", 32'h1, err);
	endtask
	// Load and count modes, wrap counting and sticky flags over the bus
	task automatic t_regs;
		logic [31:0] st;
		st = 32'(spc_pkg::MODE_LOAD) << `SPC_STATUS_MODE_LSB;
		pins(1, 0, 0, 0, 4'hF);
		apb(0, `SPC_STATUS_OFS, 32'h0);
		chk("status load", st | 32'hF, rd);
		st = 32'(spc_pkg::MODE_COUNT) << `SPC_STATUS_MODE_LSB;
		pins(1, 1, 1, 1, 4'h0);
		apb(0, `SPC_STATUS_OFS, 32'h0);
		chk("status counting", st, rd);
		pins(1, 1, 0, 0, 4'h0);
		apb(0, `SPC_WRAPS_OFS, 32'h0);
		chk("wraps", 32'h1, rd);
		chk("wraps error", 32'h0, err);
		apb(0, `SPC_FLAGS_OFS, 32'h0);
		chk("flags", 32'h7, rd);
		apb(1, `SPC_FLAGS_OFS, 32'h7);
		apb(0, `SPC_FLAGS_OFS, 32'h0);
		chk("flags cleared", 32'h0, rd);
		apb(1, `SPC_WRAPS_OFS, 32'h0);
		apb(0, `SPC_WRAPS_OFS, 32'h0);
		chk("wraps cleared", 32'h0, rd);
	endtask
	// Verdict
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 0;
		t_count();
		t_gates();
		t_clear();
		t_bus();
		t_regs();
		close_out();
	end
endmodule
